//--- pkg/lps_params.svh
`ifndef LPS_PARAMS_SVH
`define LPS_PARAMS_SVH
`define LPS_NPORTS 10
`define LPS_OFF_PORT0 8'h00
`define LPS_OFF_PORT9 8'h09
`define LPS_OFF_IN_LOW 8'h0E
`define LPS_OFF_IN_HIGH 8'h0F
`define LPS_OFF_CONFIG 8'h10
`define LPS_OFF_RAMP_DOWN 8'h11
`define LPS_OFF_RAMP_UP 8'h12
`define LPS_OFF_SCALE_LOW 8'h13
`define LPS_OFF_SCALE_HIGH 8'h14
`define LPS_OFF_GLOBAL 8'h15
`define LPS_CFG_RUN 0
`define LPS_CFG_PIN_WAKE 1
`define LPS_CFG_STAGGER 5
`define LPS_CFG_PIN_RESET 6
`define LPS_CFG_CLK_SEL 7
`define LPS_CODE_LOW 8'h00
`define LPS_CODE_RELEASE 8'h01
`define LPS_CODE_STATIC 8'h02
`define LPS_CODE_OFF 8'hFF
`define LPS_RST_PORT 8'hFF
`define LPS_RST_GLOBAL 8'h07
`define LPS_PHASE_STEP 8'h20
`define LPS_WAKE_PERIODS 8'd128
`endif

//--- pkg/lps_pkg.sv
`default_nettype none
package lps_pkg;
  typedef logic [7:0] lps_byte_t;
  typedef enum logic [2:0] {
    LPS_IDLE = 3'b001,
    LPS_WAIT = 3'b010,
    LPS_FIRE = 3'b100
  } lps_wake_e;
endpackage
`default_nettype wire

//--- design/lps_sync.sv
`default_nettype none
module lps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  // Two-flop synchroniser
  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

//--- design/lps_wake.sv
`include "lps_params.svh"
`default_nettype none
module lps_wake
  import lps_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic gate_rise,
  input wire logic gate_level,
  input wire logic pwm_tick,
  input wire logic bus_ack,
  output logic fire
);
  lps_wake_e state;
  lps_wake_e next_state;
  logic [7:0] count;
  logic [7:0] next_count;
  logic next_fire;

  // Pin-wake timer, cancelled by acks or gate drop
  always_comb begin
    next_state = state;
    next_count = count;
    next_fire = 1'b0;
    case (state)
      LPS_IDLE: begin
        next_count = 8'h00;
        if (enable && gate_rise) begin
          next_state = LPS_WAIT;
        end
      end
      LPS_WAIT: begin
        if (!enable || !gate_level || bus_ack) begin
          next_state = LPS_IDLE;
        end else if (pwm_tick) begin
          next_count = count + 8'd1;
          if (count == `LPS_WAKE_PERIODS - 8'd1) begin
            next_state = LPS_FIRE;
          end
        end
      end
      LPS_FIRE: begin
        next_fire = 1'b1;
        next_state = LPS_IDLE;
      end
      default: begin
        next_state = LPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= LPS_IDLE;
      count <= 8'h00;
      fire <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      fire <= next_fire;
    end
  end
endmodule
`default_nettype wire

//--- design/lps_core.sv
`include "lps_params.svh"
`default_nettype none
module lps_core
  import lps_pkg::*;
#(
  parameter bit HAS_EXT_CLOCK = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_gate_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic osc_tick_in,
  input wire logic external_pwm_clock_in,
  input wire logic [9:0] port_pins_in,
  output logic [9:0] port_pins_out,
  output logic [9:0] port_pins_oe_n,
  output logic [9:0] sink_enable,
  output logic [9:0] sink_full_scale,
  output logic [2:0] global_current,
  output logic [7:0] ramp_down_cfg,
  output logic [7:0] ramp_up_cfg,
  output logic run_state
);
  localparam lps_byte_t SLAVE_ADDR = 8'h40; // Arbitrary address

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [14:0] sync_q;
  lps_sync #(.WIDTH(15)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din({bus_gate_n, scl_in, sda_in, osc_tick_in, external_pwm_clock_in, port_pins_in}),
    .dout(sync_q)
  );
  logic gate_s, scl_s, sda_s, osc_s, ext_s;
  logic [9:0] pins_s;
  assign {gate_s, scl_s, sda_s, osc_s, ext_s, pins_s} = sync_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  lps_byte_t port_code [10];
  lps_byte_t config_reg, ramp_down, ramp_up, scale_low, scale_high, global_reg;
  logic scl_d, sda_d, gate_d, pwm_src_d;

  // ----------------------------------------
  // Serial slave state
  // ----------------------------------------
  typedef enum logic [4:0] {
    SL_IDLE = 5'b00001, SL_SHIFT = 5'b00010, SL_ACK = 5'b00100,
    SL_SEND = 5'b01000, SL_RACK = 5'b10000
  } lps_slave_e;
  lps_slave_e sl_state, next_sl_state;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitcnt, next_bitcnt;
  logic [1:0] phase, next_phase; // 0 addr, 1 pointer, 2 data
  logic rd_mode, next_rd_mode;
  logic [7:0] pointer, next_pointer;
  logic drive_low, next_drive_low;
  logic acked, next_acked;
  logic wr_en;
  logic [7:0] wr_addr, wr_data;

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_c = scl_s && scl_d && sda_d && !sda_s;
  wire stop_c = scl_s && scl_d && !sda_d && sda_s;

  // Register read mux, input levels masked to input ports
  function automatic lps_byte_t rd_reg(input logic [7:0] a);
    logic [9:0] lv;
    lv = '0;
    for (int i = 0; i < `LPS_NPORTS; i++) begin
      lv[i] = pins_s[i] && (port_code[i] == `LPS_CODE_RELEASE);
    end
    rd_reg = 8'h00;
    if (a <= `LPS_OFF_PORT9) rd_reg = port_code[a[3:0]];
    else if (a == `LPS_OFF_IN_LOW) rd_reg = lv[7:0];
    else if (a == `LPS_OFF_IN_HIGH) rd_reg = {6'h00, lv[9:8]};
    else if (a == `LPS_OFF_CONFIG) rd_reg = config_reg;
    else if (a == `LPS_OFF_RAMP_DOWN) rd_reg = ramp_down;
    else if (a == `LPS_OFF_RAMP_UP) rd_reg = ramp_up;
    else if (a == `LPS_OFF_SCALE_LOW) rd_reg = scale_low;
    else if (a == `LPS_OFF_SCALE_HIGH) rd_reg = scale_high;
    else if (a == `LPS_OFF_GLOBAL) rd_reg = global_reg;
  endfunction

  // Byte-level slave; sda driven only on ack/read bits
  always_comb begin
    next_sl_state = sl_state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_phase = phase;
    next_rd_mode = rd_mode;
    next_pointer = pointer;
    next_drive_low = drive_low;
    next_acked = 1'b0;
    wr_en = 1'b0;
    wr_addr = pointer;
    wr_data = shreg;
    if (!gate_s) begin
      next_sl_state = SL_IDLE;
      next_drive_low = 1'b0;
      next_bitcnt = 4'd0;
    end else if (start_c) begin
      next_sl_state = SL_SHIFT;
      next_bitcnt = 4'd0;
      next_phase = 2'd0;
      next_drive_low = 1'b0;
    end else if (stop_c) begin
      next_sl_state = SL_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (sl_state)
        SL_IDLE: begin
          next_drive_low = 1'b0;
        end
        SL_SHIFT: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'd1;
          end else if (scl_fall && bitcnt == 4'd8) begin
            next_bitcnt = 4'd0;
            if (phase == 2'd0) begin
              if (shreg[7:1] == SLAVE_ADDR[6:0]) begin
                next_rd_mode = shreg[0];
                next_drive_low = 1'b1;
                next_acked = 1'b1;
                next_sl_state = SL_ACK;
              end else begin
                next_sl_state = SL_IDLE;
              end
            end else begin
              next_drive_low = 1'b1;
              next_sl_state = SL_ACK;
              if (phase == 2'd1) begin
                next_pointer = shreg;
              end else begin
                wr_en = 1'b1;
                next_pointer = pointer + 8'd1;
              end
            end
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            next_drive_low = 1'b0;
            next_bitcnt = 4'd0;
            if (phase == 2'd0 && rd_mode) begin
              next_shreg = rd_reg(pointer);
              next_drive_low = !next_shreg[7];
              next_sl_state = SL_SEND;
            end else begin
              next_phase = (phase == 2'd0) ? 2'd1 : 2'd2;
              next_sl_state = SL_SHIFT;
            end
          end
        end
        SL_SEND: begin
          if (scl_fall) begin
            next_bitcnt = bitcnt + 4'd1;
            next_shreg = {shreg[6:0], 1'b0};
            next_drive_low = (bitcnt == 4'd7) ? 1'b0 : !shreg[6];
            if (bitcnt == 4'd7) begin
              next_pointer = pointer + 8'd1;
              next_sl_state = SL_RACK;
            end
          end
        end
        SL_RACK: begin
          if (scl_rise) begin
            next_rd_mode = sda_s; // Nack ends read
          end else if (scl_fall) begin
            next_bitcnt = 4'd0;
            if (rd_mode) begin
              next_sl_state = SL_IDLE;
            end else begin
              next_shreg = rd_reg(pointer);
              next_drive_low = !next_shreg[7];
              next_sl_state = SL_SEND;
            end
          end
        end
        default: begin
          next_sl_state = SL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sl_state <= SL_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'd0;
      phase <= 2'd0;
      rd_mode <= 1'b0;
      pointer <= 8'h00;
      drive_low <= 1'b0;
      acked <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      gate_d <= 1'b0;
    end else begin
      sl_state <= next_sl_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      phase <= next_phase;
      rd_mode <= next_rd_mode;
      pointer <= next_pointer;
      drive_low <= next_drive_low;
      acked <= next_acked;
      scl_d <= scl_s;
      sda_d <= sda_s;
      gate_d <= gate_s;
    end
  end

  // ----------------------------------------
  // PWM clock and wake timer
  // ----------------------------------------
  wire pwm_src = config_reg[`LPS_CFG_CLK_SEL] ? ext_s : osc_s;
  wire pwm_tick = pwm_src && !pwm_src_d;
  wire gate_rise = gate_s && !gate_d;
  wire gate_fall = !gate_s && gate_d;
  logic wake_fire;
  lps_wake u_wake (
    .clk(clk),
    .nrst(nrst),
    .enable(config_reg[`LPS_CFG_PIN_WAKE]),
    .gate_rise(gate_rise),
    .gate_level(gate_s),
    .pwm_tick(pwm_tick),
    .bus_ack(acked),
    .fire(wake_fire)
  );

  // ----------------------------------------
  // Register file update
  // ----------------------------------------
  lps_byte_t next_port_code [10];
  lps_byte_t next_config, next_ramp_down, next_ramp_up, next_scale_low, next_scale_high, next_global;
  wire cfg_default_clk = HAS_EXT_CLOCK;

  always_comb begin
    next_port_code = port_code;
    next_config = config_reg;
    next_ramp_down = ramp_down;
    next_ramp_up = ramp_up;
    next_scale_low = scale_low;
    next_scale_high = scale_high;
    next_global = global_reg;
    if (gate_fall && config_reg[`LPS_CFG_PIN_RESET]) begin
      for (int i = 0; i < `LPS_NPORTS; i++) next_port_code[i] = `LPS_RST_PORT;
      next_config = {cfg_default_clk, 7'h00};
      next_ramp_down = 8'h00;
      next_ramp_up = 8'h00;
      next_scale_low = 8'h00;
      next_scale_high = 8'h00;
      next_global = `LPS_RST_GLOBAL;
    end else begin
      if (wr_en) begin
        if (wr_addr <= `LPS_OFF_PORT9) next_port_code[wr_addr[3:0]] = wr_data;
        else if (wr_addr == `LPS_OFF_CONFIG) begin
          next_config = {wr_data[7:5], 3'b000, wr_data[1:0]};
          if (!HAS_EXT_CLOCK) next_config[`LPS_CFG_CLK_SEL] = 1'b0;
        end
        else if (wr_addr == `LPS_OFF_RAMP_DOWN) next_ramp_down = wr_data;
        else if (wr_addr == `LPS_OFF_RAMP_UP) next_ramp_up = wr_data;
        else if (wr_addr == `LPS_OFF_SCALE_LOW) next_scale_low = wr_data;
        else if (wr_addr == `LPS_OFF_SCALE_HIGH) next_scale_high = {6'h00, wr_data[1:0]};
        else if (wr_addr == `LPS_OFF_GLOBAL) next_global = {5'h00, wr_data[2:0]};
        // Input level offsets fall through untouched
      end
      if (wake_fire) next_config[`LPS_CFG_RUN] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `LPS_NPORTS; i++) port_code[i] <= `LPS_RST_PORT;
      config_reg <= HAS_EXT_CLOCK ? 8'h80 : 8'h00;
      ramp_down <= 8'h00;
      ramp_up <= 8'h00;
      scale_low <= 8'h00;
      scale_high <= 8'h00;
      global_reg <= `LPS_RST_GLOBAL;
      pwm_src_d <= 1'b0;
    end else begin
      port_code <= next_port_code;
      config_reg <= next_config;
      ramp_down <= next_ramp_down;
      ramp_up <= next_ramp_up;
      scale_low <= next_scale_low;
      scale_high <= next_scale_high;
      global_reg <= next_global;
      pwm_src_d <= pwm_src;
    end
  end

  // ----------------------------------------
  // PWM counter and port drive
  // ----------------------------------------
  logic [7:0] pwm_cnt;
  wire [7:0] next_pwm_cnt = pwm_tick ? pwm_cnt + 8'd1 : pwm_cnt;
  logic [9:0] next_sink, next_pin_out, next_oe_n;
  wire running = config_reg[`LPS_CFG_RUN];

  for (genvar n = 0; n < `LPS_NPORTS; n++) begin : g_port
    localparam logic [7:0] PHASE = 8'((n % 8) * `LPS_PHASE_STEP);
    wire [7:0] code = port_code[n];
    wire [7:0] offs = config_reg[`LPS_CFG_STAGGER] ? PHASE : 8'h00;
    wire [7:0] rel = pwm_cnt - offs;
    wire is_logic = (code == `LPS_CODE_LOW) || (code == `LPS_CODE_RELEASE);
    wire is_cc = !is_logic && (code != `LPS_CODE_OFF);
    wire on_time = (code == `LPS_CODE_STATIC) || (rel < code);
    always_comb begin
      next_sink[n] = running && is_cc && on_time;
      next_pin_out[n] = 1'b0;
      next_oe_n[n] = (code != `LPS_CODE_LOW);
    end
  end

  // Output registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_cnt <= 8'h00;
      sink_enable <= '0;
      port_pins_out <= '0;
      port_pins_oe_n <= '1;
      sink_full_scale <= '0;
      global_current <= 3'b111;
      ramp_down_cfg <= 8'h00;
      ramp_up_cfg <= 8'h00;
      run_state <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      pwm_cnt <= next_pwm_cnt;
      sink_enable <= next_sink;
      port_pins_out <= next_pin_out;
      port_pins_oe_n <= next_oe_n;
      sink_full_scale <= {scale_high[1:0], scale_low};
      global_current <= global_reg[2:0];
      ramp_down_cfg <= ramp_down;
      ramp_up_cfg <= ramp_up;
      run_state <= running;
      sda_out <= 1'b0;
      sda_oe_n <= !(next_drive_low && gate_s);
    end
  end
endmodule
`default_nettype wire

//--- bench/lps_host.sv
`default_nettype none
module lps_host (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Serial bus host, open drain on sda
  // ----------------------------------------
  localparam logic [7:0] ADDR_W = 8'h80;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // One scl half period of eight clocks
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  task automatic start();
    @(posedge clk);
    sda_rel <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clk);
    sda_rel <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b1;
    half();
  endtask
  // Data moves one clock after scl falls, sampled late in scl high
  task automatic bit_xfer(input logic b, output logic r);
    @(posedge clk);
    sda_rel <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = !r;
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start();
    send(ADDR_W, a0);
    send(ptr, a1);
    send(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    logic r;
    start();
    send(ADDR_W, a);
    send(ptr, a);
    stop();
    start();
    send(ADDR_W | 8'h01, a);
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(1'b1, r);
    stop();
  endtask
endmodule
`default_nettype wire

//--- bench/lps_core_chk.sv
`default_nettype none
module lps_core_chk #(
  parameter bit HAS_EXT_CLOCK = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_gate_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic osc_tick_in,
  input wire logic external_pwm_clock_in,
  input wire logic [9:0] port_pins_in,
  input wire logic [9:0] port_pins_out,
  input wire logic [9:0] port_pins_oe_n,
  input wire logic [9:0] sink_enable,
  input wire logic [9:0] sink_full_scale,
  input wire logic [2:0] global_current,
  input wire logic [7:0] ramp_down_cfg,
  input wire logic [7:0] ramp_up_cfg,
  input wire logic run_state
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Port and bus properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Gate low long enough to pass the synchroniser
  sequence s_gate_low;
    !bus_gate_n [*6];
  endsequence
  sequence s_pull_start;
    $fell(sda_oe_n);
  endsequence
  AST_OPEN_DRAIN: assert property (port_pins_out == 10'h000 && sda_out == 1'b0)
    else $error("open drain output driven high");
  AST_RESET_VALUES: assert property ($rose(nrst) |-> port_pins_oe_n == 10'h3ff && sink_enable == 10'h000
    && global_current == 3'h7 && !run_state) else $error("wrong values after reset");
  AST_GATE_RELEASE: assert property (s_gate_low |-> sda_oe_n)
    else $error("sda pulled while gate low");
  AST_GATE_HOLD: assert property (s_gate_low ##1 !bus_gate_n |-> $stable(sink_full_scale) && $stable(run_state))
    else $error("state changed while gate low");
  AST_SHUTDOWN_OFF: assert property (!run_state [*2] |-> sink_enable == 10'h000)
    else $error("sink on in shutdown");
  AST_SINK_NEEDS_RUN: assert property ((sink_enable & ~$past(sink_enable)) != 10'h000 |-> run_state)
    else $error("sink turned on without run");
  AST_NO_SINK_ON_LOW: assert property ((sink_enable & ~port_pins_oe_n) == 10'h000)
    else $error("sink on a logic low port");
  AST_PULL_BOUND: assert property (s_pull_start |-> ##[1:400] sda_oe_n)
    else $error("sda held low too long");
endmodule
`default_nettype wire

//--- bench/lps_core_tb.sv
`default_nettype none
module lps_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic nrst;
  logic bus_gate_n;
  logic osc_tick_in;
  logic external_pwm_clock_in;
  logic [9:0] port_pins_in;
  logic [9:0] port_pins_out;
  logic [9:0] port_pins_oe_n;
  logic [9:0] sink_enable;
  logic [9:0] sink_full_scale;
  logic [2:0] global_current;
  logic [7:0] ramp_down_cfg;
  logic [7:0] ramp_up_cfg;
  logic run_state;
  logic scl;
  logic sda_rel;
  logic sda_out;
  logic sda_oe_n;
  logic ack_x;
  wire logic sda_line;
  int mismatches = 0;
  int tests_run = 0;
  int on_cnt [10];
  int diff23;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  assign sda_line = sda_rel & (sda_oe_n | sda_out);
  lps_core #(.HAS_EXT_CLOCK(1'b1)) dut_u (
    .clk(clk), .nrst(nrst), .bus_gate_n(bus_gate_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .osc_tick_in(osc_tick_in),
    .external_pwm_clock_in(external_pwm_clock_in), .port_pins_in(port_pins_in),
    .port_pins_out(port_pins_out), .port_pins_oe_n(port_pins_oe_n), .sink_enable(sink_enable),
    .sink_full_scale(sink_full_scale), .global_current(global_current), .ramp_down_cfg(ramp_down_cfg),
    .ramp_up_cfg(ramp_up_cfg), .run_state(run_state)
  );
  lps_host host_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  // System clock, and PWM clocks of 8 and 16 cycles in unrelated phase
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    external_pwm_clock_in = 1'b0;
    #7;
    forever #80 external_pwm_clock_in = ~external_pwm_clock_in;
  end
  initial begin
    osc_tick_in = 1'b0;
    #3;
    forever #160 osc_tick_in = ~osc_tick_in;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host_u.wr_reg(ptr, d, ack_x);
    check(ack_x, 1'b1);
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd_reg(ptr, d);
    check(d, exp);
  endtask
  // Cycles with each sink on over a window, and cycles where ports 2 and 3 differ
  task automatic measure(input int cycles);
    for (int p = 0; p < 10; p++) on_cnt[p] = 0;
    diff23 = 0;
    repeat (cycles) begin
      @(negedge clk);
      for (int p = 0; p < 10; p++) if (sink_enable[p] === 1'b1) on_cnt[p]++;
      if (sink_enable[2] !== sink_enable[3]) diff23++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    @(negedge clk);
    check(port_pins_oe_n, 10'h3ff);
    rd(8'h10, 8'h80);
    rd(8'h13, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_scale();
    wr(8'h13, 8'ha5);
    wr(8'h14, 8'hfe);
    @(negedge clk);
    check(sink_full_scale[7:0], 8'ha5);
    check(sink_full_scale[9:8], 2'h2);
    rd(8'h13, 8'ha5);
    wr(8'h11, 8'h5a);
    wr(8'h12, 8'hc3);
    wr(8'h15, 8'hfb);
    @(negedge clk);
    check(ramp_down_cfg, 8'h5a);
    check(ramp_up_cfg, 8'hc3);
    check(global_current, 3'h3);
    $display("t_scale done");
  endtask
  task automatic t_inputs();
    wr(8'h00, 8'h01);
    wr(8'h09, 8'h01);
    wr(8'h08, 8'h00);
    @(negedge clk);
    check(port_pins_oe_n, 10'h2ff);
    rd(8'h0e, 8'h01);
    rd(8'h0f, 8'h02);
    port_pins_in <= 10'h3fe;
    rd(8'h0e, 8'h00);
    host_u.wr_reg(8'h0e, 8'hff, ack_x);
    host_u.wr_reg(8'h16, 8'h55, ack_x);
    rd(8'h0e, 8'h00);
    rd(8'h16, 8'h00);
    port_pins_in <= 10'h3ff;
    $display("t_inputs done");
  endtask
  task automatic t_pwm();
    wr(8'h10, 8'h81);
    tick(300);
    @(negedge clk);
    check(sink_enable, 10'h000);
    wr(8'h02, 8'h80);
    wr(8'h03, 8'h80);
    wr(8'h04, 8'h03);
    wr(8'h05, 8'hfe);
    wr(8'h06, 8'h02);
    wr(8'h07, 8'h00);
    measure(2048);
    check(on_cnt[2], 16'h0400);
    check(on_cnt[4], 16'h0018);
    check(on_cnt[5], 16'h07f0);
    check(on_cnt[6], 16'h0800);
    check(on_cnt[7], 16'h0000);
    check(diff23, 16'h0000);
    wr(8'h10, 8'h80);
    wr(8'h10, 8'ha0);
    wr(8'h10, 8'ha1);
    measure(2048);
    check(on_cnt[3], 16'h0400);
    check(diff23, 16'h0200);
    $display("t_pwm done");
  endtask
  task automatic t_shutdown();
    wr(8'h10, 8'ha0);
    tick(4);
    @(negedge clk);
    check(sink_enable, 10'h000);
    check(port_pins_oe_n[8], 1'b0);
    wr(8'h07, 8'h80);
    wr(8'h06, 8'h00);
    @(negedge clk);
    check(port_pins_oe_n[7:6], 2'h2);
    check(sink_enable, 10'h000);
    rd(8'h05, 8'hfe);
    wr(8'h10, 8'ha1);
    measure(2048);
    check(on_cnt[7], 16'h0400);
    check(on_cnt[6], 16'h0000);
    check(port_pins_oe_n[6], 1'b0);
    rd(8'h10, 8'ha1);
    $display("t_shutdown done");
  endtask
  task automatic t_clk_src();
    wr(8'h10, 8'h21);
    measure(4096);
    check(on_cnt[2], 16'h0800);
    check(on_cnt[5], 16'h0fe0);
    wr(8'h10, 8'h80);
    $display("t_clk_src done");
  endtask
  task automatic t_gate();
    host_u.start();
    host_u.send(8'h80, ack_x);
    host_u.send(8'h13, ack_x);
    bus_gate_n <= 1'b0;
    tick(8);
    bus_gate_n <= 1'b1;
    tick(8);
    // Data byte after the abort, with no new start, must not be taken
    host_u.send(8'h11, ack_x);
    check(ack_x, 1'b0);
    host_u.stop();
    bus_gate_n <= 1'b0;
    tick(8);
    host_u.wr_reg(8'h13, 8'h11, ack_x);
    check(ack_x, 1'b0);
    bus_gate_n <= 1'b1;
    tick(8);
    rd(8'h13, 8'ha5);
    wr(8'h13, 8'h33);
    rd(8'h13, 8'h33);
    $display("t_gate done");
  endtask
  task automatic t_wake();
    wr(8'h10, 8'h82);
    bus_gate_n <= 1'b0;
    tick(20);
    bus_gate_n <= 1'b1;
    tick(400);
    bus_gate_n <= 1'b0;
    tick(20);
    bus_gate_n <= 1'b1;
    @(negedge clk);
    check(run_state, 1'b0);
    tick(1000);
    @(negedge clk);
    check(run_state, 1'b0);
    tick(100);
    @(negedge clk);
    check(run_state, 1'b1);
    $display("t_wake done");
  endtask
  task automatic t_pin_reset();
    wr(8'h10, 8'hc1);
    bus_gate_n <= 1'b0;
    tick(20);
    bus_gate_n <= 1'b1;
    tick(8);
    @(negedge clk);
    check(run_state, 1'b0);
    check(sink_full_scale, 10'h000);
    check(global_current, 3'h7);
    rd(8'h13, 8'h00);
    rd(8'h10, 8'h80);
    $display("t_pin_reset done");
  endtask
  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    bus_gate_n = 1'b1;
    port_pins_in = 10'h3ff;
    tick(5);
    nrst <= 1'b1;
    tick(4);
    t_reset();
    t_scale();
    t_inputs();
    t_pwm();
    t_shutdown();
    t_clk_src();
    t_gate();
    t_wake();
    t_pin_reset();
    end_of_test();
  end
  // Watchdog at well over the roughly 40000 cycles the tests take
  initial begin
    tick(60000);
    mismatches++;
    end_of_test();
  end
endmodule
bind lps_core lps_core_chk #(.HAS_EXT_CLOCK(HAS_EXT_CLOCK)) chk_u (
  .clk(clk), .nrst(nrst), .bus_gate_n(bus_gate_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .osc_tick_in(osc_tick_in),
  .external_pwm_clock_in(external_pwm_clock_in), .port_pins_in(port_pins_in),
  .port_pins_out(port_pins_out), .port_pins_oe_n(port_pins_oe_n), .sink_enable(sink_enable),
  .sink_full_scale(sink_full_scale), .global_current(global_current),
  .ramp_down_cfg(ramp_down_cfg), .ramp_up_cfg(ramp_up_cfg), .run_state(run_state)
);
`default_nettype wire
